// ---- design/nand_host_pkg.sv ----
package nand_host_pkg;
   // ------------------------------------------------------------------
   // bus widths and address layout
   // ------------------------------------------------------------------
   localparam int IO_W = 16;
   localparam int ADDR_CYCLES = 5;
   localparam int COL_W_X8 = 12;
   localparam int COL_W_X16 = 11;
   localparam int ROW_W = 17;
   localparam int PLANE_BIT_X8 = 18;
   localparam int PLANE_BIT_X16 = 17;
   localparam int FIFO_DEPTH = 8;

   // ------------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------------
   localparam logic [7:0] CMD_READ_SETUP = 8'h00;
   localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int STROBE_LOW_NS = 25;
   localparam int STROBE_HIGH_NS = 25;
   localparam int READ_ACCESS_DELAY_NS = 25;
   localparam int STROBE_LOW_CYC =
      (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_HIGH_CYC =
      (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_ACCESS_DELAY_CYC =
      (READ_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_W = 4;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_COMMAND,
      OP_ADDRESS,
      OP_WRITE_DATA,
      OP_PAGE_READ
   } op_t;

   typedef struct packed {
      op_t op;
      logic [15:0] word;
      logic [11:0] column;
      logic [16:0] row;
      logic [11:0] count;
   } request_t;

   typedef struct packed {
      logic chip_select_n;
      logic cmd_latch;
      logic addr_latch;
      logic write_strobe_n;
      logic read_strobe_n;
   } strobes_t;
endpackage

// ---- design/word_fifo.sv ----
module word_fifo
   import nand_host_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] fill_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = fill_reg != (AW+1)'(DEPTH);
   assign out_valid = fill_reg != '0;
   assign out_data = mem[rd_reg];

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         fill_reg <= '0;
      end else begin
         if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         if (pop) rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         fill_reg <= fill_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // word_fifo

// ---- design/nand_host.sv ----
// Function
// - values latched on write strobe rising edge
// - address latch high marks address cycle
// - command latch high marks command cycle
// - shared I/O carries command, address, data
// - x8 column in cycles one, two
// - x8 row in cycles three to five
// - x16 column eleven bits, upper byte low
// - x16 row in cycles three to five
// - host drives unused address bits low
// - page read: 00h, five addresses, 30h, wait
module nand_host
   import nand_host_pkg::*;
#(
   parameter bit WIDE_BUS = 1'b0,
   parameter int FIFO_WORDS = FIFO_DEPTH
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // request side
   input wire logic req_valid,
   output logic req_ready,
   input wire request_t req,
   input wire logic write_protect_n_in,
   // read data side
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [IO_W-1:0] rd_data,
   output logic busy,
   // flash pins
   output logic chip_select_n,
   output logic cmd_latch,
   output logic addr_latch,
   output logic write_strobe_n,
   output logic read_strobe_n,
   output logic write_protect_n,
   input wire logic ready_busy_n,
   input wire logic [IO_W-1:0] io_in,
   output logic [IO_W-1:0] io_out,
   output logic [IO_W-1:0] io_oe
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE,
      S_WR_LOW,
      S_WR_HIGH,
      S_NEXT,
      S_WAIT_BUSY,
      S_WAIT_READY,
      S_RD_LOW,
      S_RD_HIGH
   } state_t;

   state_t state_reg, state_next;
   strobes_t pins_reg, pins_next;
   logic [IO_W-1:0] io_reg, io_next;
   logic oe_reg, oe_next;
   logic [HOLD_W-1:0] hold_reg, hold_next;
   logic [2:0] step_reg, step_next;
   logic [11:0] left_reg, left_next;
   request_t cur_reg, cur_next;
   logic cap_valid;
   logic [IO_W-1:0] cap_data;
   logic fifo_ready;

   // ------------------------------------------------------------------
   // address cycle formatting
   // ------------------------------------------------------------------
   // column and row bits are packed so the unused pins stay low
   wire [7:0] col_lo = cur_reg.column[7:0];
   wire [7:0] col_hi_x8 = {4'h0, cur_reg.column[11:8]};
   wire [7:0] col_hi_x16 = {5'h00, cur_reg.column[10:8]};
   wire [7:0] row_b0 = cur_reg.row[7:0];
   wire [7:0] row_b1 = cur_reg.row[15:8];
   wire [7:0] row_b2 = {7'h00, cur_reg.row[16]};
   wire [7:0] col_hi = WIDE_BUS ? col_hi_x16 : col_hi_x8;
   // page read sends its setup command at step 0, so its bytes lag by one
   wire [2:0] addr_idx = (cur_reg.op == OP_PAGE_READ && step_reg != 3'd0) ?
      step_reg - 3'd1 : step_reg;
   wire [7:0] addr_byte =
      (addr_idx == 3'd0) ? col_lo :
      (addr_idx == 3'd1) ? col_hi :
      (addr_idx == 3'd2) ? row_b0 :
      (addr_idx == 3'd3) ? row_b1 : row_b2;
   // upper byte is always low on address and command cycles
   wire [IO_W-1:0] addr_word = {8'h00, addr_byte};
   wire [IO_W-1:0] read_cmd_word =
      {8'h00, (step_reg == 3'd0) ? CMD_READ_SETUP : CMD_READ_CONFIRM};
   wire is_page_read = cur_reg.op == OP_PAGE_READ;
   wire page_last = step_reg == 3'd6;
   wire page_cmd = (step_reg == 3'd0) || page_last;
   wire [IO_W-1:0] data_mask = WIDE_BUS ? 16'hFFFF : 16'h00FF;
   wire hold_done = hold_reg == '0;

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      pins_next = pins_reg;
      io_next = io_reg;
      oe_next = oe_reg;
      hold_next = hold_done ? hold_reg : hold_reg - 1'b1;
      step_next = step_reg;
      left_next = left_reg;
      cur_next = cur_reg;
      cap_valid = 1'b0;
      cap_data = io_in & data_mask;
      case (state_reg)
         S_IDLE: begin
            pins_next = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
            oe_next = 1'b0;
            if (req_valid) begin
               cur_next = req;
               step_next = '0;
               left_next = req.count;
               state_next = S_NEXT;
            end
         end
         S_NEXT: begin
            // one write cycle: pick latch strobes per cycle kind
            pins_next.chip_select_n = 1'b0;
            pins_next.read_strobe_n = 1'b1;
            pins_next.write_strobe_n = 1'b0;
            oe_next = 1'b1;
            hold_next = HOLD_W'(STROBE_LOW_CYC - 1);
            state_next = S_WR_LOW;
            case (cur_reg.op)
               OP_COMMAND: begin
                  pins_next.cmd_latch = 1'b1;
                  pins_next.addr_latch = 1'b0;
                  io_next = {8'h00, cur_reg.word[7:0]};
               end
               OP_ADDRESS: begin
                  pins_next.cmd_latch = 1'b0;
                  pins_next.addr_latch = 1'b1;
                  io_next = addr_word;
               end
               OP_WRITE_DATA: begin
                  pins_next.cmd_latch = 1'b0;
                  pins_next.addr_latch = 1'b0;
                  io_next = cur_reg.word & data_mask;
               end
               OP_PAGE_READ: begin
                  pins_next.cmd_latch = page_cmd;
                  pins_next.addr_latch = !page_cmd;
                  io_next = page_cmd ? read_cmd_word : {8'h00, addr_byte};
               end
               default: state_next = S_IDLE;
            endcase
            if (is_page_read && !page_cmd) begin
               step_next = step_reg; // address index = step-1 above
            end
         end
         S_WR_LOW: begin
            if (hold_done) begin
               pins_next.write_strobe_n = 1'b1;
               hold_next = HOLD_W'(STROBE_HIGH_CYC - 1);
               state_next = S_WR_HIGH;
            end
         end
         S_WR_HIGH: begin
            if (hold_done) begin
               pins_next.cmd_latch = 1'b0;
               pins_next.addr_latch = 1'b0;
               if (cur_reg.op == OP_ADDRESS) begin
                  // only five cycles are meaningful to the device
                  step_next = step_reg + 1'b1;
                  state_next = (step_reg == 3'(ADDR_CYCLES - 1)) ?
                     S_IDLE : S_NEXT;
               end else if (is_page_read) begin
                  step_next = step_reg + 1'b1;
                  state_next = page_last ? S_WAIT_BUSY : S_NEXT;
               end else begin
                  state_next = S_IDLE;
               end
               oe_next = !(state_next == S_IDLE || page_last);
            end
         end
         S_WAIT_BUSY: begin
            // give the device time to pull busy low before trusting it
            oe_next = 1'b0;
            hold_next = HOLD_W'(STROBE_HIGH_CYC);
            state_next = S_WAIT_READY;
         end
         S_WAIT_READY: begin
            if (hold_done && ready_busy_n) begin
               state_next = (left_reg == '0) ? S_IDLE : S_RD_LOW;
               if (left_reg != '0) begin
                  pins_next.read_strobe_n = 1'b0;
                  hold_next = HOLD_W'(READ_ACCESS_DELAY_CYC);
               end
            end
         end
         S_RD_LOW: begin
            if (hold_done && fifo_ready) begin
               cap_valid = 1'b1;
               pins_next.read_strobe_n = 1'b1;
               left_next = left_reg - 1'b1;
               hold_next = HOLD_W'(STROBE_HIGH_CYC - 1);
               state_next = S_RD_HIGH;
            end
         end
         S_RD_HIGH: begin
            if (hold_done) begin
               if (left_reg == '0) begin
                  state_next = S_IDLE;
               end else begin
                  pins_next.read_strobe_n = 1'b0;
                  hold_next = HOLD_W'(READ_ACCESS_DELAY_CYC);
                  state_next = S_RD_LOW;
               end
            end
         end
         default: state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= S_IDLE;
         pins_reg <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
         io_reg <= '0;
         oe_reg <= 1'b0;
         hold_reg <= '0;
         step_reg <= '0;
         left_reg <= '0;
         cur_reg <= '0;
      end else begin
         state_reg <= state_next;
         pins_reg <= pins_next;
         io_reg <= io_next;
         oe_reg <= oe_next;
         hold_reg <= hold_next;
         step_reg <= step_next;
         left_reg <= left_next;
         cur_reg <= cur_next;
      end
   end

   // ------------------------------------------------------------------
   // read data buffer
   // ------------------------------------------------------------------
   // a full buffer stalls the read strobe, so no word is ever dropped
   word_fifo #(
      .WIDTH(IO_W),
      .DEPTH(FIFO_WORDS)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(cap_valid),
      .in_ready(fifo_ready),
      .in_data(cap_data),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   // ------------------------------------------------------------------
   // pin outputs
   // ------------------------------------------------------------------
   assign req_ready = state_reg == S_IDLE;
   assign busy = state_reg != S_IDLE;
   assign chip_select_n = pins_reg.chip_select_n;
   assign cmd_latch = pins_reg.cmd_latch;
   assign addr_latch = pins_reg.addr_latch;
   assign write_strobe_n = pins_reg.write_strobe_n;
   assign read_strobe_n = pins_reg.read_strobe_n;
   // write protect passes through; low keeps the array safe
   assign write_protect_n = write_protect_n_in;
   assign io_out = io_reg;
   assign io_oe = {IO_W{oe_reg}};
endmodule // nand_host

// ---- tb/nand_host_props.sv ----
module nand_host_props
   import nand_host_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // host side
   input wire logic write_protect_n_in,
   // flash pins
   input wire logic chip_select_n,
   input wire logic cmd_latch,
   input wire logic addr_latch,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic write_protect_n,
   input wire logic ready_busy_n,
   input wire logic [IO_W-1:0] io_out,
   input wire logic [IO_W-1:0] io_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ---------------------------------------------------------------
   // pin relations
   // ---------------------------------------------------------------
   AST_WP_PASS: assert property (write_protect_n == write_protect_n_in)
      else $error("write protect not passed through");
   AST_WE_PULSE: assert property ($fell(write_strobe_n) |=>
      write_strobe_n && !chip_select_n)
      else $error("write strobe low phase not one cycle");
   AST_WE_MODE: assert property (!write_strobe_n |->
      !chip_select_n && read_strobe_n)
      else $error("write strobe without select or with read strobe");
   AST_LATCH_ONE: assert property (!(cmd_latch && addr_latch))
      else $error("both latch strobes high");
   AST_RE_MODE: assert property (!read_strobe_n |-> write_strobe_n &&
      !cmd_latch && !addr_latch && !chip_select_n)
      else $error("read strobe in wrong bus mode");
   AST_DRIVE_WRITE: assert property (!write_strobe_n |->
      io_oe[7:0] == 8'hff)
      else $error("bus not driven during write strobe");
   AST_FLOAT_READ: assert property (!read_strobe_n |->
      io_oe == {IO_W{1'b0}})
      else $error("bus driven during read strobe");
   AST_HOLD_EDGE: assert property (!write_strobe_n |=>
      $stable(io_out) && $stable(cmd_latch) && $stable(addr_latch))
      else $error("bus value moved at write strobe rise");
   AST_WAIT_READY: assert property (!ready_busy_n |-> read_strobe_n)
      else $error("read strobe while device busy");
endmodule // nand_host_props

bind nand_host nand_host_props chk (.clock, .rst, .write_protect_n_in,
   .chip_select_n, .cmd_latch, .addr_latch, .write_strobe_n,
   .read_strobe_n, .write_protect_n, .ready_busy_n, .io_out, .io_oe);

// ---- tb/flash_model.sv ----
module flash_model
   import nand_host_pkg::*;
#(
   parameter int BUSY_CYC = 20
) (
   // busy timer clock
   input wire logic clock,
   // control pins
   input wire logic chip_select_n,
   input wire logic cmd_latch,
   input wire logic addr_latch,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   // data pins and ready line
   input wire logic [IO_W-1:0] bus,
   output logic pull_low,
   output logic dev_oe,
   output logic [IO_W-1:0] dev_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] addr_byte [ADDR_CYCLES];
   logic [11:0] column = '0;
   logic plane = 1'b0;
   int n_addr = 0;
   initial begin
      pull_low = 1'b0;
      dev_oe = 1'b0;
      dev_data = '0;
   end
   // strobes are missed while busy, as no command is legal then
   always @(posedge write_strobe_n) begin
      if (!chip_select_n && addr_latch && !cmd_latch
          && n_addr < ADDR_CYCLES) begin
         addr_byte[n_addr] = bus[7:0];
         n_addr++;
      end
      if (!chip_select_n && cmd_latch && !addr_latch) begin
         if (bus[7:0] == CMD_READ_SETUP) n_addr = 0;
         if (bus[7:0] == CMD_READ_CONFIRM) begin
            column = {addr_byte[1][3:0], addr_byte[0]};
            plane = addr_byte[2][6];
            #1 pull_low = 1'b1;
            repeat (BUSY_CYC) @(posedge clock);
            pull_low = 1'b0;
         end
      end
   end
   always @(negedge read_strobe_n) begin
      if (!chip_select_n) begin
         dev_data = {8'h00, column[7:0] ^ 8'h25 ^ {plane, 7'h00}};
         dev_oe = 1'b1;
      end
   end
   // hold ends with the strobe
   always @(posedge read_strobe_n) begin
      dev_oe = 1'b0;
      column++;
   end
   always @(posedge chip_select_n) dev_oe = 1'b0;
endmodule // flash_model

// ---- tb/tb_nand_host.sv ----
module tb_nand_host
   import nand_host_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 0, rst = 1, req_valid = 0, rd_ready = 0, wp_in = 1;
   logic stall = 0, req_ready, rd_valid, busy, chip_select_n, cmd_latch;
   logic addr_latch, write_strobe_n, read_strobe_n, write_protect_n;
   logic ready_busy_n, pull_low, dev_oe;
   logic [IO_W-1:0] rd_data, io_in, io_out, io_oe, dev_data, w;
   logic [11:0] col;
   logic [16:0] row;
   request_t req = '0;
   logic [9:0] wr_q [$];
   logic [IO_W-1:0] rd_q [$];
   int failures = 0, total_checks = 0, seed = 32'hbb75_4cdf;
   nand_host uut (.clock, .rst, .req_valid, .req_ready, .req,
      .write_protect_n_in(wp_in), .rd_valid, .rd_ready, .rd_data, .busy,
      .chip_select_n, .cmd_latch, .addr_latch, .write_strobe_n,
      .read_strobe_n, .write_protect_n, .ready_busy_n, .io_in, .io_out,
      .io_oe);
   flash_model #(.BUSY_CYC(20)) dev (.clock, .chip_select_n, .cmd_latch,
      .addr_latch, .write_strobe_n, .read_strobe_n, .bus(io_out),
      .pull_low, .dev_oe, .dev_data);
   // released bus shows the inverse of the device's last data
   assign io_in = dev_oe ? dev_data : (io_oe[0] ? io_out : ~dev_data);
   assign ready_busy_n = pull_low ? 1'b0 : 1'b1;
   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      wp_in <= ($random(seed) & 1) != 0;
      rd_ready <= !stall && ($random(seed) & 1) != 0;
   end
   // ---------------------------------------------------------------
   // compare tasks and monitors
   // ---------------------------------------------------------------
   task automatic check_wr(input logic [9:0] seen);
      logic [9:0] exp;
      exp = 'x;
      if (wr_q.size() > 0) exp = wr_q.pop_front();
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] bus cycle exp %h seen %h", exp, seen);
      end
   endtask
   task automatic check_rd(input logic [IO_W-1:0] seen);
      logic [IO_W-1:0] exp;
      exp = 'x;
      if (rd_q.size() > 0) exp = rd_q.pop_front();
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] read word exp %h seen %h", exp, seen);
      end
   endtask
   always @(posedge write_strobe_n) begin
      if (!chip_select_n && !rst) begin
         check_wr({cmd_latch, addr_latch, io_out[7:0]});
      end
   end
   always @(posedge clock) begin
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
         check_rd(rd_data);
      end
   end
   // ---------------------------------------------------------------
   // request tasks
   // ---------------------------------------------------------------
   task automatic do_req(input request_t r);
      int n;
      req <= r;
      req_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (req_ready !== 1'b1 && n < 100);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (busy !== 1'b0 && n < 3000);
      if (n >= 3000) failures++;
   endtask
   task automatic push_addr(input logic [11:0] c, input logic [16:0] r);
      wr_q.push_back({2'b01, c[7:0]});
      wr_q.push_back({2'b01, 4'h0, c[11:8]});
      wr_q.push_back({2'b01, r[7:0]});
      wr_q.push_back({2'b01, r[15:8]});
      wr_q.push_back({2'b01, 7'h00, r[16]});
   endtask
   task automatic page_read(input logic [11:0] c, input logic [16:0] r,
                            input int cnt);
      logic [11:0] k;
      wr_q.push_back({2'b10, CMD_READ_SETUP});
      push_addr(c, r);
      wr_q.push_back({2'b10, CMD_READ_CONFIRM});
      for (int i = 0; i < cnt; i++) begin
         k = c + 12'(i);
         rd_q.push_back({8'h00, k[7:0] ^ 8'h25 ^ {r[6], 7'h00}});
      end
      do_req('{OP_PAGE_READ, 16'h0000, c, r, 12'(cnt)});
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clock);
      failures++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         w = 16'($random(seed)) | 16'h0001;
         wr_q.push_back({2'b10, w[7:0]});
         do_req('{OP_COMMAND, w, 12'h000, 17'h0_0000, 12'h000});
      end
      $display("test commands done");
      col = 12'($random(seed));
      row = 17'($random(seed));
      push_addr(col, row);
      do_req('{OP_ADDRESS, 16'h0000, col, row, 12'h000});
      w = 16'($random(seed));
      wr_q.push_back({2'b00, w[7:0]});
      do_req('{OP_WRITE_DATA, w, 12'h000, 17'h0_0000, 12'h000});
      $display("test address and data done");
      stall <= 1'b1;
      fork
         page_read(12'($random(seed)), 17'($random(seed)), 12);
         begin
            repeat (300) @(posedge clock);
            stall <= 1'b0;
         end
      join
      page_read(12'hffe, 17'h1_ffff, 4);
      $display("test page reads done");
      repeat (20) @(posedge clock);
      total_checks++;
      if (wr_q.size() != 0 || rd_q.size() != 0) begin
         failures++;
         $display("[ERR] queues exp 0 seen %0d", wr_q.size() + rd_q.size());
      end
      print_verdict();
   end
endmodule // tb_nand_host
